// *** dv/operator_model.sv ***
// Operator side: mode switch and motion-side parameter lookup
`timescale 1ns/1ns
module operator_model (
	input  wire logic        pclk,
	input  wire logic [31:0] look_data,
	output logic             hand_operation_mode,
	output logic             look_axis_y,
	output logic      [6:0]  look_num
);
	// ************************************************************
	// Initial levels: manual mode, lookup idle
	// ************************************************************
	initial begin
		hand_operation_mode = 1'b1;
		look_axis_y = 1'b0;
		look_num = 7'h00;
	end

	// ************************************************************
	// Mode change and lookup
	// ************************************************************
	task automatic go_auto();
		@(posedge pclk);
		hand_operation_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		hand_operation_mode <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask

	task automatic look(input logic y, input logic [6:0] n, output logic [31:0] d);
		@(posedge pclk);
		look_axis_y <= y;
		look_num <= n;
		@(posedge pclk);
		@(negedge pclk);
		d = look_data;
	endtask
endmodule

// *** dv/tb_top.sv ***
// Testbench: APB tests of the parameter store
`timescale 1ns/1ns
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic        hand_operation_mode, look_axis_y, fault_lamp_x, fault_lamp_y, halt_positioning;
	logic [7:0]  paddr;
	logic [6:0]  look_num;
	logic [31:0] pwdata, prdata, look_data, q;
	logic [31:0] prdata_s, look_data_s;
	logic        pready_s, pslverr_s, lamp_x_s, lamp_y_s, halt_s;
	int          err_count, samples_checked, cycles;

	positioning_parameter_store #(.two_axis(1'b1)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hand_operation_mode(hand_operation_mode), .look_axis_y(look_axis_y),
		.look_num(look_num), .look_data(look_data), .fault_lamp_x(fault_lamp_x),
		.fault_lamp_y(fault_lamp_y), .halt_positioning(halt_positioning));

	operator_model op (.pclk(pclk), .look_data(look_data),
		.hand_operation_mode(hand_operation_mode), .look_axis_y(look_axis_y),
		.look_num(look_num));

	// Single-axis variant on the same bus, in lockstep with dut
	positioning_parameter_store #(.two_axis(1'b0)) solo (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s),
		.hand_operation_mode(hand_operation_mode), .look_axis_y(look_axis_y),
		.look_num(look_num), .look_data(look_data_s), .fault_lamp_x(lamp_x_s),
		.fault_lamp_y(lamp_y_s), .halt_positioning(halt_s));

	// ************************************************************
	// Clock, timeout, verdict
	// ************************************************************
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial cycles = 0;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			conclude();
		end
	end

	task automatic conclude();
		if (err_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string w, input logic [31:0] seen, input logic [31:0] x);
		samples_checked++;
		if (seen !== x) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", w, x, seen);
		end
	endtask

	// ************************************************************
	// APB access
	// ************************************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 400);
		if (pready !== 1'b1) begin
			err_count++;
		end
		r = prdata;
		s = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic s;
		apb(1'b1, a, d, r, s);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input string w);
		logic [31:0] r;
		logic s;
		apb(1'b0, a, 32'h0, r, s);
		check(w, r & m, x);
	endtask

	task automatic sel(input logic [6:0] n, input logic y);
		wr(param_store_pkg::SEL_OFF, {23'h0, y, 1'b0, n});
	endtask

	task automatic panel(input logic [6:0] n, input logic y, input logic [31:0] d);
		sel(n, y);
		wr(param_store_pkg::PANEL_OFF, d);
	endtask

	task automatic pins(input logic [2:0] x);
		@(negedge pclk);
		check("lamps", {29'h0, fault_lamp_x, fault_lamp_y, halt_positioning}, {29'h0, x});
	endtask

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdc(param_store_pkg::SEL_OFF, 32'hffffffff, {24'h0, param_store_pkg::SEL_RESET}, "sel");
		apb(1'b0, 8'h14, 32'h0, q, e);
		check("slverr", {31'h0, e}, 32'h1);
		check("unmapped", q, 32'h0);
		panel(7'h04, 1'b0, 32'h3e8);
		rdc(param_store_pkg::PANEL_OFF, 32'hffffffff, 32'h3e8, "held x4");
		rdc(param_store_pkg::PROG_OFF, 32'hffffffff, 32'h3e8, "shadow x4");
		panel(7'h04, 1'b1, 32'h7d0);
		rdc(param_store_pkg::PROG_OFF, 32'hffffffff, 32'h7d0, "shadow y4");
		op.look(1'b0, 7'h04, q);
		check("look x4", q, 32'h3e8);
		wr(param_store_pkg::CTRL_OFF, 32'h1);
		op.look(1'b1, 7'h04, q);
		check("look sim y4", q, 32'h3e8);
		wr(param_store_pkg::CTRL_OFF, 32'h0);
		op.look(1'b1, 7'h04, q);
		check("look y4", q, 32'h7d0);
		check("solo look y4", look_data_s, 32'h7d0);
		panel(7'h1e, 1'b0, 32'h5);
		rdc(param_store_pkg::PANEL_OFF, 32'hffffffff, 32'h5, "held 30");
		panel(7'h64, 1'b0, 32'h9);
		sel(7'h64, 1'b1);
		rdc(param_store_pkg::PANEL_OFF, 32'hffffffff, 32'h9, "held 100");
		sel(7'h04, 1'b0);
		wr(param_store_pkg::PROG_OFF, 32'h30d41);
		rdc(param_store_pkg::PROG_OFF, 32'hffffffff, 32'h30d40, "clamp hi");
		rdc(param_store_pkg::STATUS_OFF, 32'h3, 32'h0, "prog err");
		pins(3'b000);
		wr(param_store_pkg::PROG_OFF, 32'h0);
		rdc(param_store_pkg::PROG_OFF, 32'hffffffff, 32'h1, "clamp lo");
		panel(7'h00, 1'b0, 32'h1);
		wr(param_store_pkg::PROG_OFF, 32'h3);
		rdc(param_store_pkg::PROG_OFF, 32'hffffffff, 32'h1, "kept");
		sel(7'h04, 1'b0);
		wr(param_store_pkg::PROG_OFF, 32'h1f4);
		op.look(1'b0, 7'h04, q);
		check("look prog", q, 32'h1f4);
		op.go_auto();
		rdc(param_store_pkg::CTRL_OFF, 32'h2, 32'h2, "busy");
		rdc(param_store_pkg::STATUS_OFF, 32'h3, 32'h0, "reload done");
		op.look(1'b0, 7'h04, q);
		check("look reload", q, 32'h3e8);
		panel(7'h03, 1'b1, 32'h4);
		rdc(param_store_pkg::STATUS_OFF, 32'h0fff0003,
			{4'h0, param_store_pkg::ERR_CODE_BASE + 12'h003, 16'h0002}, "err y3");
		pins(3'b011);
		check("solo lamps", {29'h0, lamp_x_s, lamp_y_s, halt_s}, 32'h5);
		panel(7'h03, 1'b1, 32'h2);
		rdc(param_store_pkg::STATUS_OFF, 32'h3, 32'h0, "clear y");
		pins(3'b000);
		panel(7'h09, 1'b0, 32'h0);
		rdc(param_store_pkg::STATUS_OFF, 32'h0fff0003,
			{4'h0, param_store_pkg::ERR_CODE_BASE + 12'h009, 16'h0001}, "err x9");
		pins(3'b101);
		panel(7'h09, 1'b0, 32'h5);
		pins(3'b000);
		sel(7'h04, 1'b0);
		wr(param_store_pkg::PROG_OFF, 32'h4d);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(param_store_pkg::CTRL_OFF, 32'h2, 32'h2, "busy");
		rdc(param_store_pkg::STATUS_OFF, 32'h3, 32'h0, "power-on status");
		op.look(1'b0, 7'h04, q);
		check("look power-on", q, 32'h3e8);
		conclude();
	end
endmodule

// *** src/param_store_pkg.sv ***
// Package: register map, limits and types for the parameter store
package param_store_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] SEL_OFF    = 8'h04;
	localparam logic [7:0] PANEL_OFF  = 8'h08;
	localparam logic [7:0] PROG_OFF   = 8'h0c;
	localparam logic [7:0] STATUS_OFF = 8'h10;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int         CTRL_SIM_BIT   = 0;
	localparam int         CTRL_BUSY_BIT  = 1;
	localparam int         SEL_AXIS_BIT   = 8;
	localparam int         STAT_ERRX_BIT  = 0;
	localparam int         STAT_ERRY_BIT  = 1;
	localparam int         STAT_CODE_LSB  = 16;
	localparam logic [7:0] SEL_RESET      = 8'h00;
	localparam logic [7:0] IO_GROUP_BASE  = 8'h1e;
	localparam logic [7:0] SYS_GROUP_BASE = 8'h64;
	localparam logic [6:0] LAST_INDEX     = 7'h7f;
	localparam logic [11:0] ERR_CODE_BASE = 12'h7d0;
	localparam logic [11:0] ERR_CODE_LAST = 12'h808;
	localparam logic [7:0] ERR_NUM_LAST   = 8'h38;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [31:0] lo;
		logic [31:0] hi;
		logic        clamp;
		logic        checked;
	} limit_type;

	typedef struct packed {
		logic       axis_y;
		logic [6:0] num;
	} select_type;

	typedef enum logic {st_reload, st_idle} state_type;

	// Range of each parameter; clamp marks time and speed parameters
	function automatic limit_type limit_of(input logic [6:0] num);
		limit_type l;
		l = '{lo: 32'h0, hi: 32'hffffffff, clamp: 1'b0, checked: 1'b0};
		case (num)
			7'h00, 7'h12: l = '{32'h0, 32'h2, 1'b0, 1'b1};
			7'h01:        l = '{32'h1, 32'hffff, 1'b0, 1'b1};
			7'h02:        l = '{32'h1, 32'hf423f, 1'b0, 1'b1};
			7'h03:        l = '{32'h0, 32'h3, 1'b0, 1'b1};
			7'h04, 7'h05: l = '{32'h1, 32'h30d40, 1'b1, 1'b1};
			7'h06:        l = '{32'h1, 32'h4e20, 1'b1, 1'b1};
			7'h07, 7'h11: l = '{32'h0, 32'hffff, 1'b0, 1'b1};
			7'h08, 7'h09: l = '{32'h1, 32'h1388, 1'b1, 1'b1};
			7'h0a:        l = '{32'h0, 32'h1388, 1'b1, 1'b1};
			7'h0b, 7'h0c, 7'h0f, 7'h13, 7'h14: l = '{32'h0, 32'h1, 1'b0, 1'b1};
			7'h0d:        l = '{32'ha, 32'h30d40, 1'b1, 1'b1};
			7'h0e:        l = '{32'ha, 32'h4e20, 1'b1, 1'b1};
			default:      l = l;
		endcase
		return l;
	endfunction

endpackage

// *** src/positioning_parameter_store.sv ***
// Parameter store: held memory, shadow registers, range checks, APB slave
// ************************************************************
// ************************************************************
`timescale 1ns/1ns
module positioning_parameter_store #(
	parameter bit two_axis = 1'b1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hand_operation_mode,
	input  wire logic        look_axis_y,
	input  wire logic [6:0]  look_num,
	output logic      [31:0] look_data,
	output logic             fault_lamp_x,
	output logic             fault_lamp_y,
	output logic             halt_positioning
);

	// ************************************************************
	// Storage
	// ************************************************************
	logic [31:0] held_x   [128];
	logic [31:0] held_y   [128];
	logic [31:0] shadow_x [128];
	logic [31:0] shadow_y [128];

	param_store_pkg::state_type  state;
	param_store_pkg::select_type sel;
	param_store_pkg::limit_type  lim;
	param_store_pkg::limit_type  look_lim;
	logic [6:0]  idx;
	logic        sim_two_axis;
	logic        err_x;
	logic        err_y;
	logic [6:0]  err_num_x;
	logic [6:0]  err_num_y;
	logic [11:0] err_code;
	logic        mode_meta;
	logic        mode_sync;
	logic        mode_prev;
	logic        to_auto;
	logic        access;
	logic        wr;
	logic        on_y;
	logic        panel_wr;
	logic        prog_wr;
	logic        in_range;
	logic        panel_ok;
	logic        panel_bad;
	logic [31:0] prog_value;
	logic        prog_store;
	logic        look_y;
	logic [31:0] next_rdata;
	logic        next_err;

	// ************************************************************
	// Mode pin synchroniser and manual to automatic edge
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_meta <= 1'b1;
			mode_sync <= 1'b1;
			mode_prev <= 1'b1;
		end else begin
			mode_meta <= hand_operation_mode;
			mode_sync <= mode_meta;
			mode_prev <= mode_sync;
		end
	end

	assign to_auto = mode_prev & ~mode_sync;

	// ************************************************************
	// Access decode
	// ************************************************************
	assign access   = psel & penable & pready;
	assign wr       = access & pwrite;
	assign on_y     = two_axis & sel.axis_y & (sel.num < 7'(param_store_pkg::SYS_GROUP_BASE));
	assign panel_wr = wr & (paddr == param_store_pkg::PANEL_OFF);
	assign prog_wr  = wr & (paddr == param_store_pkg::PROG_OFF);
	assign lim      = param_store_pkg::limit_of(sel.num);
	assign in_range = !lim.checked || (pwdata >= lim.lo && pwdata <= lim.hi);
	assign panel_ok  = panel_wr & in_range;
	assign panel_bad = panel_wr & ~in_range;

	always_comb begin
		prog_store = 1'b1;
		prog_value = pwdata;
		if (!in_range) begin
			if (!lim.clamp) begin
				prog_store = 1'b0;
			end else if (pwdata > lim.hi) begin
				prog_value = lim.hi;
			end else begin
				prog_value = lim.lo;
			end
		end
	end

	// ************************************************************
	// Reload sequencer
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= param_store_pkg::st_reload;
			idx   <= 7'h00;
		end else if (to_auto) begin
			state <= param_store_pkg::st_reload;
			idx   <= 7'h00;
		end else begin
			case (state)
				param_store_pkg::st_reload: begin
					idx <= idx + 7'h01;
					if (idx == param_store_pkg::LAST_INDEX) begin
						state <= param_store_pkg::st_idle;
					end
				end
				default: begin
					idx <= 7'h00;
				end
			endcase
		end
	end

	// ************************************************************
	// Held memory, kept through reset
	// ************************************************************
	always_ff @(posedge pclk) begin
		if (panel_ok && !on_y) begin
			held_x[sel.num] <= pwdata;
		end
		if (panel_ok && on_y) begin
			held_y[sel.num] <= pwdata;
		end
	end

	// ************************************************************
	// Shadow registers
	// ************************************************************
	always_ff @(posedge pclk) begin
		if (state == param_store_pkg::st_reload) begin
			shadow_x[idx] <= held_x[idx];
			shadow_y[idx] <= held_y[idx];
		end else if (panel_ok) begin
			if (on_y) begin
				shadow_y[sel.num] <= pwdata;
			end else begin
				shadow_x[sel.num] <= pwdata;
			end
		end else if (prog_wr && prog_store) begin
			if (on_y) begin
				shadow_y[sel.num] <= prog_value;
			end else begin
				shadow_x[sel.num] <= prog_value;
			end
		end
	end

	// ************************************************************
	// Motion lookup port
	// ************************************************************
	assign look_lim = param_store_pkg::limit_of(look_num);
	assign look_y   = two_axis & look_axis_y
		& (look_num < 7'(param_store_pkg::SYS_GROUP_BASE))
		& ~(sim_two_axis & look_lim.clamp);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			look_data <= 32'h0;
		end else begin
			look_data <= look_y ? shadow_y[look_num] : shadow_x[look_num];
		end
	end

	// ************************************************************
	// Parameter set error
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_x     <= 1'b0;
			err_y     <= 1'b0;
			err_num_x <= 7'h00;
			err_num_y <= 7'h00;
			err_code  <= 12'h000;
		end else if (panel_bad) begin
			if (on_y) begin
				err_y     <= 1'b1;
				err_num_y <= sel.num;
			end else begin
				err_x     <= 1'b1;
				err_num_x <= sel.num;
			end
			err_code <= (sel.num > 7'(param_store_pkg::ERR_NUM_LAST))
				? param_store_pkg::ERR_CODE_LAST
				: param_store_pkg::ERR_CODE_BASE + 12'(sel.num);
		end else if (panel_ok) begin
			if (on_y && sel.num == err_num_y) begin
				err_y <= 1'b0;
			end
			if (!on_y && sel.num == err_num_x) begin
				err_x <= 1'b0;
			end
		end
	end

	assign fault_lamp_x     = err_x;
	assign fault_lamp_y     = err_y;
	assign halt_positioning = err_x | err_y;

	// ************************************************************
	// APB slave: one wait state per access; during reload, accesses other than CTRL wait until the sequencer is idle
	// ************************************************************
	always_comb begin
		next_rdata = 32'h0;
		next_err   = 1'b0;
		if (paddr == param_store_pkg::CTRL_OFF) begin
			next_rdata[param_store_pkg::CTRL_SIM_BIT]  = sim_two_axis;
			next_rdata[param_store_pkg::CTRL_BUSY_BIT] = (state == param_store_pkg::st_reload);
		end else if (paddr == param_store_pkg::SEL_OFF) begin
			next_rdata[param_store_pkg::SEL_AXIS_BIT] = sel.axis_y;
			next_rdata[6:0] = sel.num;
		end else if (paddr == param_store_pkg::PANEL_OFF) begin
			next_rdata = on_y ? held_y[sel.num] : held_x[sel.num];
		end else if (paddr == param_store_pkg::PROG_OFF) begin
			next_rdata = on_y ? shadow_y[sel.num] : shadow_x[sel.num];
		end else if (paddr == param_store_pkg::STATUS_OFF) begin
			next_rdata[param_store_pkg::STAT_ERRX_BIT] = err_x;
			next_rdata[param_store_pkg::STAT_ERRY_BIT] = err_y;
			next_rdata[param_store_pkg::STAT_CODE_LSB +: 12] = err_code;
		end else begin
			next_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & penable & ~pready & ~to_auto
				& ((state == param_store_pkg::st_idle) | (paddr == param_store_pkg::CTRL_OFF));
			pslverr <= psel & penable & ~pready & next_err;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? next_rdata : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sim_two_axis <= 1'b0;
			sel          <= param_store_pkg::select_type'(param_store_pkg::SEL_RESET);
		end else if (wr && paddr == param_store_pkg::CTRL_OFF) begin
			sim_two_axis <= pwdata[param_store_pkg::CTRL_SIM_BIT];
		end else if (wr && paddr == param_store_pkg::SEL_OFF) begin
			sel <= {pwdata[param_store_pkg::SEL_AXIS_BIT], pwdata[6:0]};
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RELOAD_COPY: assert property (state == param_store_pkg::st_reload && !to_auto
		|=> shadow_x[$past(idx)] === held_x[$past(idx)])
		else $error("Shadow not reloaded from held memory");
	AST_AUTO_RELOAD: assert property ($fell(mode_sync) |-> ##1 state == param_store_pkg::st_reload
		##127 state == param_store_pkg::st_reload ##1 state == param_store_pkg::st_idle)
		else $error("Automatic entry did not reload");
	AST_PANEL_BOTH: assert property (panel_ok && !on_y |=> held_x[$past(sel.num)] == $past(pwdata)
		&& shadow_x[$past(sel.num)] == $past(pwdata))
		else $error("Panel write missed held or shadow copy");
	AST_PANEL_ERR: assert property (panel_bad |=> halt_positioning
		&& err_code >= param_store_pkg::ERR_CODE_BASE && err_code <= param_store_pkg::ERR_CODE_LAST)
		else $error("Bad panel write did not halt");
	AST_LAMP: assert property (panel_bad && on_y |=> fault_lamp_y)
		else $error("Fault lamp Y not lit");
	AST_PROG_NO_ERR: assert property (prog_wr |=> $stable(halt_positioning) && $stable(err_code))
		else $error("Program write raised an error");
	AST_CLAMP_HI: assert property (prog_wr && !on_y && lim.clamp && pwdata > lim.hi
		|=> shadow_x[$past(sel.num)] == $past(lim.hi))
		else $error("Program write not clamped to maximum");
	AST_CLAMP_LO: assert property (prog_wr && !on_y && lim.clamp && pwdata < lim.lo
		|=> shadow_x[$past(sel.num)] == $past(lim.lo))
		else $error("Program write not clamped to minimum");
	AST_KEEP: assert property (prog_wr && !on_y && !in_range && !lim.clamp
		|=> $stable(shadow_x[sel.num]))
		else $error("Bad program write changed value");
	AST_SINGLE: assert property (!two_axis |-> !fault_lamp_y)
		else $error("Single-axis variant flagged Y");
	AST_LAMP_X: assert property (panel_bad && !on_y |=> fault_lamp_x)
		else $error("Fault lamp X not lit");
	AST_CLEAR_X: assert property (panel_ok && !on_y && sel.num == err_num_x
		|=> !fault_lamp_x)
		else $error("Valid rewrite left error X set");
	AST_CLEAR_Y: assert property (panel_ok && on_y && sel.num == err_num_y
		|=> !fault_lamp_y)
		else $error("Valid rewrite left error Y set");
	AST_HALT_HOLD: assert property (halt_positioning && !panel_ok |=> halt_positioning)
		else $error("Error left without a valid rewrite");
	AST_PROG_USE: assert property (prog_wr && prog_store && !on_y
		|=> shadow_x[$past(sel.num)] == $past(prog_value))
		else $error("Program write not applied to shadow");
	AST_SIM_SHARE: assert property (sim_two_axis && look_axis_y && look_lim.clamp
		|=> look_data == $past(shadow_x[look_num]))
		else $error("Simultaneous lookup did not use X set");

	// ************************************************************
	// Cover properties
	// ************************************************************
	COV_PANEL_ERR: cover property (panel_bad ##[1:50] panel_ok && !halt_positioning);
	COV_CLAMP: cover property (prog_wr && lim.clamp && !in_range);
	COV_AUTO: cover property ($fell(mode_sync) ##129 state == param_store_pkg::st_idle);
	COV_SIM_LOOK: cover property (sim_two_axis && look_axis_y && look_lim.clamp);
	COV_PROG_KEEP: cover property (prog_wr && !prog_store);

endmodule
